// File: tb_top.sv
`timescale 1ns/1ns
`include "tdbr_map.svh"
module tb_top;
    localparam logic [1:0] OK = `TDBR_RESP_OKAY;
    localparam logic [1:0] ERR = `TDBR_RESP_SLVERR;
    // Response readies stay high so back-to-back transfers never re-drive them in one step
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic timer_dma_trig = 0, go = 0, prev_req = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [31:0] seed = 32'h0000_0041;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  dly = 2'h0, bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, dma_req, dma_ack, burst_busy;
    logic [33:0] exp_q[$];
    logic [31:0] shadow[32];
    int          error_cnt = 0, num_checks = 0, req_cnt = 0, cyc = 0, n0 = 0;

    always #50 aclk = ~aclk;

    tdbr_top tdbr_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .timer_dma_trig, .dma_req, .dma_ack, .burst_busy);
    tdbr_dma_model tdbr_dma_model_i (.aclk, .aresetn, .dma_req, .go, .dly, .dma_ack);

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit aw = 1'b1;
        bit w = 1'b1;
        exp_q.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'h0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'h0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({r, d});
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'b1);
    endtask : rd

    task automatic trig(input int n);
        n0 = req_cnt;
        timer_dma_trig <= 1'h1;
        repeat (n) @(posedge aclk);
        timer_dma_trig <= 1'h0;
    endtask : trig

    // Plays the DMA side: fixed window address, memory index base + k % per steps per beat and wraps every per beats
    task automatic run(input int n, input bit w, input logic [4:0] base, input int per);
        logic [4:0] idx;
        for (int k = 0; k < n; k++) begin
            idx = base + 5'(k % per);
            do @(posedge aclk); while (dma_req !== 1'b1);
            if (w) begin
                shadow[idx] = xs();
                wr(`TDBR_BURST_WINDOW, shadow[idx], OK);
            end else begin
                rd(`TDBR_BURST_WINDOW, shadow[idx], OK);
            end
            dly <= 2'(xs());
            go <= 1'h1;
            @(posedge aclk);
            go <= 1'h0;
            do @(posedge aclk); while (dma_req === 1'b1);
        end
        @(posedge aclk);
        chk(34'(burst_busy), 34'h0, "burst_busy");
    endtask : run

    always @(posedge aclk) begin
        prev_req <= dma_req;
        if (dma_req === 1'b1 && prev_req !== 1'b1)
            req_cnt++;
        if (bvalid === 1'b1 && bready)
            chk({bresp, 32'h0}, exp_q.pop_front(), "write response");
        if (rvalid === 1'b1 && rready)
            chk({rresp, rdata}, exp_q.pop_front(), "read data");
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        for (int i = 0; i < 32; i++) shadow[i] = 32'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(`TDBR_BURST_CONTROL, 32'h0, OK);
        rd(`TDBR_PERIOD_RELOAD, 32'h0, OK);
        rd(8'h90, 32'h0, ERR);
        wr(`TDBR_BURST_CONTROL, 32'h0000_020B, OK);
        rd(`TDBR_BURST_CONTROL, 32'h0000_020B, OK);
        wr(`TDBR_DMA_ENABLE, 32'h1, OK);
        $display("test reset_map done");
        trig(1);
        run(3, 1'b1, 5'd11, 3);
        chk(34'(req_cnt - n0), 34'h3, "request count");
        for (int i = 11; i < 14; i++) rd(8'(i * 4), shadow[i], OK);
        $display("test write_burst done");
        trig(3);
        run(6, 1'b0, 5'd11, 3);
        chk(34'(req_cnt - n0), 34'h6, "request count");
        $display("test read_pending done");
        wr(`TDBR_BURST_CONTROL, 32'h0000_011F, OK);
        trig(1);
        run(2, 1'b1, 5'd31, 2);
        chk(34'(req_cnt - n0), 34'h2, "request count");
        rd(`TDBR_BURST_WINDOW, shadow[31], OK);
        rd(`TDBR_TIMER_CONTROL_ONE, shadow[0], OK);
        $display("test wrap done");
        wstrb <= 4'h1;
        wr(`TDBR_BURST_CONTROL, 32'h0000_0203, OK);
        wstrb <= 4'hF;
        rd(`TDBR_BURST_CONTROL, 32'h0000_0103, OK);
        $display("test lanes done");
        wr(`TDBR_BURST_CONTROL, 32'h0, OK);
        trig(1);
        run(1, 1'b1, 5'd0, 1);
        repeat (4) @(posedge aclk);
        chk(34'(req_cnt - n0), 34'h1, "request count");
        rd(`TDBR_TIMER_CONTROL_ONE, shadow[0], OK);
        $display("test single done");
        wr(`TDBR_BURST_STATUS, 32'hFFFF_FFFF, OK);
        rd(`TDBR_BURST_STATUS, 32'h0, OK);
        wr(8'h90, 32'h0, ERR);
        rd(8'h01, 32'h0, ERR);
        $display("test status done");
        wr(`TDBR_DMA_ENABLE, 32'h0, OK);
        trig(1);
        repeat (10) @(posedge aclk);
        chk(34'(req_cnt - n0), 34'h0, "request count");
        chk(34'(burst_busy), 34'h0, "burst_busy");
        $display("test disabled done");
        finish_test();
    end
endmodule : tb_top

// File: tdbr_dma_model.sv
`timescale 1ns/1ns
module tdbr_dma_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       dma_req,
    input  wire logic       go,
    input  wire logic [1:0] dly,
    output logic            dma_ack
);
    logic       armed_ff;
    logic [1:0] cnt_ff;

    // Ack only after the bench has finished the window access of this beat
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_ff <= 1'h0;
            cnt_ff <= 2'h0;
            dma_ack <= 1'h0;
        end else begin
            dma_ack <= 1'h0;
            if (go) begin
                armed_ff <= 1'h1;
                cnt_ff <= dly;
            end else if (armed_ff && dma_req) begin
                if (cnt_ff == 2'h0) begin
                    dma_ack <= 1'h1;
                    armed_ff <= 1'h0;
                end else begin
                    cnt_ff <= cnt_ff - 2'h1;
                end
            end
        end
    end
endmodule : tdbr_dma_model

// File: tdbr_map.svh
`ifndef TDBR_MAP_SVH
`define TDBR_MAP_SVH

// Byte addresses on the register bus
`define TDBR_PHYS_LAST     8'h7C
`define TDBR_BURST_CONTROL 8'h80
`define TDBR_BURST_WINDOW  8'h84
`define TDBR_DMA_ENABLE    8'h88
`define TDBR_BURST_STATUS  8'h8C

// Physical timer register offsets (index = offset / 4)
`define TDBR_TIMER_CONTROL_ONE 8'h00
`define TDBR_PERIOD_RELOAD     8'h2C

// burst_control fields
`define TDBR_BASE_LSB 0
`define TDBR_BASE_MSB 4
`define TDBR_LEN_LSB  8
`define TDBR_LEN_MSB  12

// dma_enable field
`define TDBR_REQ_EN_BIT 0

// burst_status fields
`define TDBR_ST_BUSY_BIT 0
`define TDBR_ST_PEND_BIT 1
`define TDBR_ST_BEAT_LSB 8
`define TDBR_ST_BEAT_MSB 12

// Reset values
`define TDBR_BURST_CONTROL_RST 32'h0000_0000
`define TDBR_DMA_ENABLE_RST    1'h0
`define TDBR_PHYS_RST          32'h0000_0000

// Bus responses
`define TDBR_RESP_OKAY   2'h0
`define TDBR_RESP_SLVERR 2'h2

`endif

// File: tdbr_pkg.sv
package tdbr_pkg;

    typedef enum logic [1:0] {
        TDBR_IDLE = 2'b00,
        TDBR_REQ  = 2'b01,
        TDBR_GAP  = 2'b10
    } tdbr_fsm_t;

    typedef enum logic [2:0] {
        TDBR_K_PHYS = 3'b000,
        TDBR_K_BCTL = 3'b001,
        TDBR_K_WIN  = 3'b010,
        TDBR_K_EN   = 3'b011,
        TDBR_K_STAT = 3'b100,
        TDBR_K_BAD  = 3'b101
    } tdbr_kind_t;

    typedef struct packed {
        logic [31:0][31:0] regs;
        logic [4:0]        len;
        logic [4:0]        base;
        logic [4:0]        beat;
        logic              req_en;
        logic              pend;
        tdbr_fsm_t         fsm;
        logic              aw_got;
        logic [7:0]        aw_addr;
        logic              w_got;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } tdbr_st_t;

endpackage : tdbr_pkg

// File: tdbr_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`include "tdbr_map.svh"
// Overview of operation
// - One internal timer trigger yields a series of successive DMA requests.
// - The burst window has no storage; each access goes to a physical register.
// - Window reads return, and writes update, the currently targeted register.
// - Target register comes from burst control settings and sequencer state.
// - A 5-bit burst length field sets the beats per burst.
// - A 5-bit base index picks the first of up to 32 registers.
// - Register index equals byte offset divided by four.
// - Length zero gives one request per trigger, otherwise length plus one.
// - First request follows the trigger; each next one waits for the previous acknowledge.
// - Acknowledge of the final beat ends the burst; new triggers are accepted.
// - Each successive beat redirects the window to the next register from base.
// - After the last beat the pointer returns to the base register.
// - Only software-enabled timer DMA triggers are raised and pass the burst logic.
// - Read bursts use the same sequencing; only direction and addresses change.
module tdbr_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        timer_dma_trig,
    output logic             dma_req,
    input  wire logic        dma_ack,
    output logic             burst_busy
);
    import tdbr_pkg::*;

    tdbr_st_t   st_ff;
    tdbr_st_t   nxt_st;
    logic [4:0] ptr;
    tdbr_kind_t wr_kind;

    function automatic tdbr_kind_t decode(input logic [7:0] a);
        tdbr_kind_t k;
        k = TDBR_K_BAD;
        if (a[1:0] != 2'h0) begin
            k = TDBR_K_BAD;
        end else if (a <= `TDBR_PHYS_LAST) begin
            k = TDBR_K_PHYS;
        end else begin
            case (a)
                `TDBR_BURST_CONTROL: k = TDBR_K_BCTL;
                `TDBR_BURST_WINDOW:  k = TDBR_K_WIN;
                `TDBR_DMA_ENABLE:    k = TDBR_K_EN;
                `TDBR_BURST_STATUS:  k = TDBR_K_STAT;
                default:             k = TDBR_K_BAD;
            endcase
        end
        return k;
    endfunction : decode

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Redirection pointer: base plus beat, wrapping in the 32-entry map
    assign ptr = 5'(st_ff.base + st_ff.beat);
    assign wr_kind = decode(st_ff.aw_addr);

    // Data need not wait for its address; each write channel stalls on its own buffer and on a pending write response, reads only on a pending read response
    assign awready    = !st_ff.aw_got && !st_ff.bvalid;
    assign wready     = !st_ff.w_got && !st_ff.bvalid;
    assign arready    = !st_ff.rvalid;
    assign bvalid     = st_ff.bvalid;
    assign bresp      = st_ff.bresp;
    assign rvalid     = st_ff.rvalid;
    assign rresp      = st_ff.rresp;
    assign rdata      = st_ff.rdata;
    assign dma_req    = (st_ff.fsm == TDBR_REQ);
    assign burst_busy = (st_ff.fsm != TDBR_IDLE);

    always_comb begin
        tdbr_kind_t rk;
        nxt_st = st_ff;
        rk     = decode(araddr);

        if (awvalid && awready) begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_st.w_got  = 1'b1;
            nxt_st.w_data = wdata;
            nxt_st.w_strb = wstrb;
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // Burst sequencer
        case (st_ff.fsm)
            TDBR_IDLE: begin
                if (st_ff.pend) begin
                    nxt_st.pend = 1'b0;
                    nxt_st.beat = 5'h00;
                    nxt_st.fsm  = TDBR_REQ;
                end
            end
            TDBR_REQ: begin
                if (dma_ack) begin
                    if (st_ff.beat == st_ff.len) begin
                        nxt_st.beat = 5'h00;
                        nxt_st.fsm  = TDBR_IDLE;
                    end else begin
                        nxt_st.beat = 5'(st_ff.beat + 5'h01);
                        nxt_st.fsm  = TDBR_GAP;
                    end
                end
            end
            TDBR_GAP: begin
                // Request drops for one cycle so every beat is a fresh request
                nxt_st.fsm = TDBR_REQ;
            end
            default: begin
                nxt_st.fsm = TDBR_IDLE;
            end
        endcase

        // Set wins over the start of a burst consuming the previous trigger
        if (timer_dma_trig && st_ff.req_en) begin
            nxt_st.pend = 1'b1;
        end

        // Write executes once both address and data are held
        if (st_ff.aw_got && st_ff.w_got) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = `TDBR_RESP_OKAY;
            case (wr_kind)
                TDBR_K_PHYS: begin
                    nxt_st.regs[st_ff.aw_addr[6:2]] =
                        merge(st_ff.regs[st_ff.aw_addr[6:2]], st_ff.w_data, st_ff.w_strb);
                end
                TDBR_K_BCTL: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.base = st_ff.w_data[`TDBR_BASE_MSB:`TDBR_BASE_LSB];
                    end
                    if (st_ff.w_strb[1]) begin
                        nxt_st.len = st_ff.w_data[`TDBR_LEN_MSB:`TDBR_LEN_LSB];
                    end
                    nxt_st.beat = 5'h00;
                end
                TDBR_K_WIN: begin
                    nxt_st.regs[ptr] = merge(st_ff.regs[ptr], st_ff.w_data, st_ff.w_strb);
                end
                TDBR_K_EN: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.req_en = st_ff.w_data[`TDBR_REQ_EN_BIT];
                    end
                end
                TDBR_K_STAT: begin
                    nxt_st.bresp = `TDBR_RESP_OKAY;
                end
                default: begin
                    nxt_st.bresp = `TDBR_RESP_SLVERR;
                end
            endcase
        end

        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = `TDBR_RESP_OKAY;
            nxt_st.rdata  = 32'h0000_0000;
            case (rk)
                TDBR_K_PHYS: nxt_st.rdata = st_ff.regs[araddr[6:2]];
                TDBR_K_BCTL: begin
                    nxt_st.rdata[`TDBR_BASE_MSB:`TDBR_BASE_LSB] = st_ff.base;
                    nxt_st.rdata[`TDBR_LEN_MSB:`TDBR_LEN_LSB]   = st_ff.len;
                end
                TDBR_K_WIN:  nxt_st.rdata = st_ff.regs[ptr];
                TDBR_K_EN:   nxt_st.rdata[`TDBR_REQ_EN_BIT] = st_ff.req_en;
                TDBR_K_STAT: begin
                    nxt_st.rdata[`TDBR_ST_BUSY_BIT] = (st_ff.fsm != TDBR_IDLE);
                    nxt_st.rdata[`TDBR_ST_PEND_BIT] = st_ff.pend;
                    nxt_st.rdata[`TDBR_ST_BEAT_MSB:`TDBR_ST_BEAT_LSB] = st_ff.beat;
                end
                default:     nxt_st.rresp = `TDBR_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    start_on_pending_a: assert property ((st_ff.fsm == TDBR_IDLE) && st_ff.pend |=> dma_req && st_ff.beat == 5'h00)
        else $error("pending trigger did not start a burst");

    next_after_ack_a: assert property (dma_req && dma_ack && st_ff.beat != st_ff.len
                                       |=> !dma_req ##1 dma_req)
        else $error("next beat request not issued after acknowledge");

    last_beat_end_a: assert property (dma_req && dma_ack && st_ff.beat == st_ff.len
                                      |=> !burst_busy && st_ff.beat == 5'h00)
        else $error("burst did not end on final acknowledge");

    single_req_a: assert property (dma_req && dma_ack && st_ff.len == 5'h00 |=> !dma_req)
        else $error("zero length gave more than one request");

    beat_step_a: assert property (dma_req && dma_ack && st_ff.beat != st_ff.len
                                  |=> ptr == 5'($past(ptr) + 5'h01))
        else $error("pointer did not step to next register");

    beat_bound_a: assert property (st_ff.beat <= st_ff.len)
        else $error("beat count above burst length");

    trig_held_a: assert property (timer_dma_trig && st_ff.req_en && burst_busy |=> st_ff.pend)
        else $error("trigger during burst was lost");

    trig_masked_a: assert property (timer_dma_trig && !st_ff.req_en && !st_ff.pend && !burst_busy
                                    |=> !st_ff.pend ##1 !dma_req)
        else $error("disabled trigger raised a request");

    window_read_a: assert property (arvalid && arready && araddr == `TDBR_BURST_WINDOW
                                    |=> rvalid && rdata == $past(st_ff.regs[ptr]))
        else $error("window read did not return target register");

    ctrl_write_a: assert property (st_ff.aw_got && st_ff.w_got && wr_kind == TDBR_K_BCTL
                                   |=> st_ff.beat == 5'h00 && bvalid)
        else $error("burst control write did not reset pointer");

    // Handshake, pointer and refusal checks
    req_hold_a: assert property (dma_req && !dma_ack |=> dma_req)
        else $error("request dropped before its acknowledge");

    gap_one_cycle_a: assert property (burst_busy && !dma_req |=> dma_req)
        else $error("gap between beats lasted more than one cycle");

    idle_base_a: assert property (!burst_busy |-> ptr == st_ff.base)
        else $error("pointer not at base while idle");

    no_pend_idle_a: assert property ((st_ff.fsm == TDBR_IDLE) && !st_ff.pend |=> !dma_req)
        else $error("request raised without a pending trigger");

    pend_clear_a: assert property ((st_ff.fsm == TDBR_IDLE) && st_ff.pend && !(timer_dma_trig && st_ff.req_en)
                                   |=> !st_ff.pend)
        else $error("pending trigger not consumed at burst start");

    write_resp_a: assert property (st_ff.aw_got && st_ff.w_got |=> bvalid)
        else $error("write response not raised");

    read_resp_a: assert property (arvalid && arready |=> rvalid)
        else $error("read response not raised");

    window_write_a: assert property (st_ff.aw_got && st_ff.w_got && wr_kind == TDBR_K_WIN && st_ff.w_strb == 4'hF
                                     |=> st_ff.regs[$past(ptr)] == $past(st_ff.w_data))
        else $error("window write did not reach target register");

    bad_read_a: assert property (arvalid && arready && araddr > `TDBR_BURST_STATUS
                                 |=> rresp == `TDBR_RESP_SLVERR)
        else $error("unmapped read not refused");

    stat_write_a: assert property (st_ff.aw_got && st_ff.w_got && wr_kind == TDBR_K_STAT
                                   |=> bresp == `TDBR_RESP_OKAY)
        else $error("status write not answered OKAY");

    burst_multi_c: cover property (dma_req && dma_ack && st_ff.len == 5'h02 && st_ff.beat == 5'h02);
    burst_single_c: cover property (dma_req && dma_ack && st_ff.len == 5'h00);
    trig_pending_c: cover property (timer_dma_trig && st_ff.req_en && burst_busy);
    window_write_c: cover property (st_ff.aw_got && st_ff.w_got && wr_kind == TDBR_K_WIN && burst_busy);

endmodule : tdbr_top
